// >>> rtl/cqdf_pkg.sv
package cqdf_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int NCH   = 2;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int CNT_W = 24;

    // ****************************************************************
    // register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [5:0] IDX_CFG_A  = 6'h1a;
    localparam logic [5:0] IDX_CFG_B  = 6'h1b;
    localparam logic [5:0] IDX_DRV    = 6'h1c;
    localparam logic [5:0] IDX_CLKCFG = 6'h1d;
    localparam logic [5:0] IDX_FAULT  = 6'h20;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_AUX_LVL  = 7;
    localparam int BIT_LINE_LVL = 6;
    localparam int BIT_DRV_EN   = 5;
    localparam int BIT_DRV_DAT  = 4;
    localparam int BIT_FILT_ON  = 3;
    localparam int BIT_THR_SEL  = 2;
    localparam int BIT_SRC_ON   = 1;
    localparam int BIT_SNK_ON   = 0;
    localparam int CFG_RW_W     = 6;
    localparam int LIM_SEL_LSB  = 6;
    localparam int BIT_LIM_OFF  = 5;
    localparam int BLANK_LSB    = 3;
    localparam int RETRY_LSB    = 1;
    localparam int BIT_RETRY_EN = 0;
    localparam int BIT_PIN_DIS  = 6;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [CFG_RW_W-1:0] RST_CFG = 6'h00;
    localparam logic [7:0]          RST_DRV = 8'h00;
    localparam logic                RST_PCD = 1'b0;

    // ****************************************************************
    // times and derived cycle counts
    // ****************************************************************
    localparam int CLK_PERIOD_NS      = 50;
    localparam int T_FILT_NS          = 1300;
    localparam int T_BLANK_128US_NS   = 128000;
    localparam int T_BLANK_500US_NS   = 500000;
    localparam int T_BLANK_1MS_NS     = 1000000;
    localparam int T_BLANK_5MS_NS     = 5000000;
    localparam int T_RETRY_50MS_NS    = 50000000;
    localparam int T_RETRY_100MS_NS   = 100000000;
    localparam int T_RETRY_200MS_NS   = 200000000;
    localparam int T_RETRY_500MS_NS   = 500000000;

    // least times round up to whole cycles
    function automatic int cyc_up(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int FILT_W          = 5;
    localparam int FILT_CYC        = cyc_up(T_FILT_NS);
    localparam int BLANK_128US_CYC = cyc_up(T_BLANK_128US_NS);

    // fault controller states, gray along run, off, check
    typedef enum logic [1:0] {
        CQDF_RUN   = 2'b00,
        CQDF_OFF   = 2'b01,
        CQDF_CHECK = 2'b11
    } cqdf_fstate_t;

endpackage

// >>> rtl/cqdf_fault_if.sv
`timescale 1ns/1ps
interface cqdf_fault_if;
    import cqdf_pkg::*;

    logic [CNT_W-1:0] blank_cyc;
    logic [CNT_W-1:0] retry_cyc;
    logic             retry_en;
    logic             overcurrent;
    logic             drive_req;
    logic             drive_ok;
    logic             fault;

    modport ctl  (input blank_cyc, retry_cyc, retry_en, overcurrent, drive_req, output drive_ok, fault);
    modport host (output blank_cyc, retry_cyc, retry_en, overcurrent, drive_req, input drive_ok, fault);

endinterface // cqdf_fault_if

// >>> rtl/cqdf_fault_ctl.sv
`timescale 1ns/1ps
module cqdf_fault_ctl
    import cqdf_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    cqdf_fault_if.ctl   fb
);

    cqdf_fstate_t     state_r;
    cqdf_fstate_t     state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             fault_r;
    logic             fault_nxt;
    logic             ok_r;
    logic             ok_nxt;

    // ****************************************************************
    // blanking, off-time and recheck sequencing
    // ****************************************************************
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        fault_nxt = fault_r;
        ok_nxt    = ok_r;
        case (state_r)
            CQDF_RUN:
            begin
                ok_nxt = 1'b1;
                // only an unbroken overcurrent of the full blanking time counts
                if (fb.drive_req && fb.overcurrent)
                begin
                    if (cnt_r == fb.blank_cyc - 24'h1)
                    begin
                        state_nxt = CQDF_OFF;
                        cnt_nxt   = '0;
                        fault_nxt = 1'b1;
                        ok_nxt    = 1'b0;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 24'h1;
                    end
                end
                else
                begin
                    cnt_nxt = '0;
                end
            end
            CQDF_OFF:
            begin
                ok_nxt = 1'b0;
                // without retry the driver stays latched off
                if (fb.retry_en)
                begin
                    if (cnt_r == fb.retry_cyc - 24'h1)
                    begin
                        state_nxt = CQDF_CHECK;
                        cnt_nxt   = '0;
                        ok_nxt    = 1'b1;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 24'h1;
                    end
                end
                else
                begin
                    cnt_nxt = '0;
                end
            end
            CQDF_CHECK:
            begin
                ok_nxt = 1'b1;
                // wait out blanking, then look once
                if (cnt_r == fb.blank_cyc - 24'h1)
                begin
                    cnt_nxt = '0;
                    if (fb.overcurrent)
                    begin
                        state_nxt = CQDF_OFF;
                        ok_nxt    = 1'b0;
                    end
                    else
                    begin
                        state_nxt = CQDF_RUN;
                        fault_nxt = 1'b0;
                    end
                end
                else
                begin
                    cnt_nxt = cnt_r + 24'h1;
                end
            end
            default:
            begin
                state_nxt = CQDF_RUN;
                cnt_nxt   = '0;
                fault_nxt = 1'b0;
                ok_nxt    = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= CQDF_RUN;
            cnt_r   <= '0;
            fault_r <= 1'b0;
            ok_r    <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            fault_r <= fault_nxt;
            ok_r    <= ok_nxt;
        end
    end

    assign fb.drive_ok = ok_r;
    assign fb.fault    = fault_r;

endmodule // cqdf_fault_ctl

// >>> rtl/cqdf_top.sv
`timescale 1ns/1ps
module cqdf_top
    import cqdf_pkg::*;
#(
    parameter int BLANK_500US_CYC = cyc_up(T_BLANK_500US_NS),
    parameter int BLANK_1MS_CYC   = cyc_up(T_BLANK_1MS_NS),
    parameter int BLANK_5MS_CYC   = cyc_up(T_BLANK_5MS_NS),
    parameter int RETRY_50MS_CYC  = cyc_up(T_RETRY_50MS_NS),
    parameter int RETRY_100MS_CYC = cyc_up(T_RETRY_100MS_NS),
    parameter int RETRY_200MS_CYC = cyc_up(T_RETRY_200MS_NS),
    parameter int RETRY_500MS_CYC = cyc_up(T_RETRY_500MS_NS)
)
(
    input  wire logic             REF_CLK,
    input  wire logic             RESETN,
    input  wire logic             WB_CYC_I,
    input  wire logic             WB_STB_I,
    input  wire logic             WB_WE_I,
    input  wire logic [ADR_W-1:0] WB_ADR_I,
    input  wire logic [DAT_W-1:0] WB_DAT_I,
    input  wire logic [3:0]       WB_SEL_I,
    output logic      [DAT_W-1:0] WB_DAT_O,
    output logic                  WB_ACK_O,
    input  wire logic [NCH-1:0]   DRIVE_ENABLE_PIN,
    input  wire logic [NCH-1:0]   DRIVE_DATA_PIN,
    input  wire logic [NCH-1:0]   AUX_INPUT,
    input  wire logic [NCH-1:0]   LINE_I,
    input  wire logic [NCH-1:0]   OVERCURRENT,
    output logic      [NCH-1:0]   LINE_O,
    output logic      [NCH-1:0]   LINE_OE,
    output logic      [NCH-1:0]   THRESHOLD_TYPE_SEL,
    output logic      [NCH-1:0]   INPUT_SOURCE_ON,
    output logic      [NCH-1:0]   INPUT_SINK_ON,
    output logic      [1:0]       DRIVER_LIMIT_SELECT,
    output logic                  DRIVER_LIMIT_OFF,
    output logic      [NCH-1:0]   DRIVER_FAULT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    localparam int SYNC_W = 5 * NCH;

    logic [SYNC_W-1:0]   sync1_r;
    logic [SYNC_W-1:0]   sync2_r;
    logic [NCH-1:0]      en_pin;
    logic [NCH-1:0]      dat_pin;
    logic [NCH-1:0]      aux_in;
    logic [NCH-1:0]      line_in;
    logic [NCH-1:0]      oc_in;

    logic [CFG_RW_W-1:0] cfg_r   [NCH];
    logic [CFG_RW_W-1:0] cfg_nxt [NCH];
    logic [7:0]          drv_r;
    logic [7:0]          drv_nxt;
    logic                pcd_r;
    logic                pcd_nxt;
    logic                ack_r;
    logic                ack_nxt;
    logic [DAT_W-1:0]    dat_r;
    logic [DAT_W-1:0]    dat_nxt;

    logic [NCH-1:0]      lvl_r;
    logic [NCH-1:0]      lvl_nxt;
    logic [FILT_W-1:0]   fcnt_r   [NCH];
    logic [FILT_W-1:0]   fcnt_nxt [NCH];

    logic [NCH-1:0]      oe_r;
    logic [NCH-1:0]      oe_nxt;
    logic [NCH-1:0]      do_r;
    logic [NCH-1:0]      do_nxt;
    logic [NCH-1:0]      flt_r;

    logic [NCH-1:0]      drive_ok;
    logic [NCH-1:0]      fault;
    logic [CNT_W-1:0]    blank_sel;
    logic [CNT_W-1:0]    retry_sel;
    logic                req;
    logic [5:0]          idx;

    // register bit or pin, depending on pin-control-disable
    function automatic logic pick(input logic dis, input logic reg_bit, input logic pin_bit);
        return dis ? reg_bit : pin_bit;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // pins are asynchronous to REF_CLK; first stage feeds only the second
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {OVERCURRENT, LINE_I, AUX_INPUT, DRIVE_DATA_PIN, DRIVE_ENABLE_PIN};
            sync2_r <= sync1_r;
        end
    end

    assign en_pin  = sync2_r[NCH-1:0];
    assign dat_pin = sync2_r[2*NCH-1:NCH];
    assign aux_in  = sync2_r[3*NCH-1:2*NCH];
    assign line_in = sync2_r[4*NCH-1:3*NCH];
    assign oc_in   = sync2_r[5*NCH-1:4*NCH];

    // ****************************************************************
    // wishbone slave and register file
    // ****************************************************************
    assign req = WB_CYC_I & WB_STB_I;
    assign idx = WB_ADR_I[ADR_W-1:2];

    // ack one cycle after the request; writes land on the ack edge
    always_comb
    begin
        cfg_nxt = cfg_r;
        drv_nxt = drv_r;
        pcd_nxt = pcd_r;
        dat_nxt = dat_r;
        ack_nxt = req & ~ack_r;
        if (req && !ack_r)
        begin
            case (idx)
                IDX_CFG_A:  dat_nxt = DAT_W'({lvl_r[0], line_in[0], cfg_r[0]});
                IDX_CFG_B:  dat_nxt = DAT_W'({lvl_r[1], line_in[1], cfg_r[1]});
                IDX_DRV:    dat_nxt = DAT_W'(drv_r);
                IDX_CLKCFG: dat_nxt = DAT_W'(pcd_r) << BIT_PIN_DIS;
                IDX_FAULT:  dat_nxt = DAT_W'(fault);
                default:    dat_nxt = '0;
            endcase
        end
        // level bits sit above the writable field, so writes skip them
        if (req && ack_r && WB_WE_I && WB_SEL_I[0])
        begin
            case (idx)
                IDX_CFG_A:  cfg_nxt[0] = WB_DAT_I[CFG_RW_W-1:0];
                IDX_CFG_B:  cfg_nxt[1] = WB_DAT_I[CFG_RW_W-1:0];
                IDX_DRV:    drv_nxt    = WB_DAT_I[7:0];
                IDX_CLKCFG: pcd_nxt    = WB_DAT_I[BIT_PIN_DIS];
                default:    drv_nxt    = drv_r;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cfg_r <= '{default: RST_CFG};
            drv_r <= RST_DRV;
            pcd_r <= RST_PCD;
            ack_r <= 1'b0;
            dat_r <= '0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            drv_r <= drv_nxt;
            pcd_r <= pcd_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // ****************************************************************
    // auxiliary input glitch filter
    // ****************************************************************
    // a change is taken only after it holds for the full filter time
    always_comb
    begin
        lvl_nxt  = lvl_r;
        fcnt_nxt = fcnt_r;
        for (int i = 0; i < NCH; i++)
        begin
            if (!cfg_r[i][BIT_FILT_ON])
            begin
                lvl_nxt[i]  = aux_in[i];
                fcnt_nxt[i] = '0;
            end
            else if (aux_in[i] == lvl_r[i])
            begin
                fcnt_nxt[i] = '0;
            end
            else if (fcnt_r[i] == FILT_W'(FILT_CYC - 1))
            begin
                lvl_nxt[i]  = aux_in[i];
                fcnt_nxt[i] = '0;
            end
            else
            begin
                fcnt_nxt[i] = fcnt_r[i] + 5'h01;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            lvl_r  <= '0;
            fcnt_r <= '{default: '0};
        end
        else
        begin
            lvl_r  <= lvl_nxt;
            fcnt_r <= fcnt_nxt;
        end
    end

    // ****************************************************************
    // shared timing decode
    // ****************************************************************
    always_comb
    begin
        case (drv_r[BLANK_LSB +: 2])
            2'b00:   blank_sel = CNT_W'(BLANK_128US_CYC);
            2'b01:   blank_sel = CNT_W'(BLANK_500US_CYC);
            2'b10:   blank_sel = CNT_W'(BLANK_1MS_CYC);
            default: blank_sel = CNT_W'(BLANK_5MS_CYC);
        endcase
        case (drv_r[RETRY_LSB +: 2])
            2'b00:   retry_sel = CNT_W'(RETRY_50MS_CYC);
            2'b01:   retry_sel = CNT_W'(RETRY_100MS_CYC);
            2'b10:   retry_sel = CNT_W'(RETRY_200MS_CYC);
            default: retry_sel = CNT_W'(RETRY_500MS_CYC);
        endcase
    end

    // ****************************************************************
    // per-channel fault controllers
    // ****************************************************************
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        cqdf_fault_if fif ();

        assign fif.blank_cyc   = blank_sel;
        assign fif.retry_cyc   = retry_sel;
        assign fif.retry_en    = drv_r[BIT_RETRY_EN];
        assign fif.overcurrent = oc_in[g];
        assign fif.drive_req   = pick(pcd_r, cfg_r[g][BIT_DRV_EN], en_pin[g]);
        assign drive_ok[g]     = fif.drive_ok;
        assign fault[g]        = fif.fault;

        cqdf_fault_ctl u_ctl (
            .clk   (REF_CLK),
            .rst_n (RESETN),
            .fb    (fif.ctl)
        );
    end

    // ****************************************************************
    // line driver outputs
    // ****************************************************************
    // a faulted driver is held off whatever the enable source says, except in the blanking window of a retry check
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            oe_nxt[i] = pick(pcd_r, cfg_r[i][BIT_DRV_EN], en_pin[i]) & drive_ok[i];
            do_nxt[i] = pick(pcd_r, cfg_r[i][BIT_DRV_DAT], dat_pin[i]);
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            oe_r  <= '0;
            do_r  <= '0;
            flt_r <= '0;
        end
        else
        begin
            oe_r  <= oe_nxt;
            do_r  <= do_nxt;
            flt_r <= fault;
        end
    end

    assign LINE_OE      = oe_r;
    assign LINE_O       = do_r;
    assign DRIVER_FAULT = flt_r;

    // ****************************************************************
    // analogue control straps
    // ****************************************************************
    // straight from the register flops, no extra stage
    for (genvar c = 0; c < NCH; c++)
    begin : g_ana
        assign THRESHOLD_TYPE_SEL[c] = cfg_r[c][BIT_THR_SEL];
        assign INPUT_SOURCE_ON[c]    = cfg_r[c][BIT_SRC_ON];
        assign INPUT_SINK_ON[c]      = cfg_r[c][BIT_SNK_ON];
    end

    assign DRIVER_LIMIT_SELECT = drv_r[LIM_SEL_LSB +: 2];
    assign DRIVER_LIMIT_OFF    = drv_r[BIT_LIM_OFF];

endmodule // cqdf_top

// >>> tb/cqdf_line_model.sv
`timescale 1ns/1ps
// ********
// field device on the line
// ********
module cqdf_line_model
    import cqdf_pkg::*;
(
    input  wire logic [NCH-1:0] drv_o,
    input  wire logic [NCH-1:0] drv_oe,
    input  wire logic [NCH-1:0] sensor_lvl,
    input  wire logic [NCH-1:0] shorted,
    output logic      [NCH-1:0] line_lvl,
    output logic      [NCH-1:0] overcurrent
);
    // master wins while it drives, else the sensor output shows
    assign line_lvl = (drv_oe & drv_o) | (~drv_oe & sensor_lvl);
    // a short only loads the driver while it drives
    assign overcurrent = shorted & drv_oe;
endmodule // cqdf_line_model

// >>> tb/cqdf_top_sva.sv
`timescale 1ns/1ps
module cqdf_top_sva
    import cqdf_pkg::*;
#(
    parameter int BLANK_500US_CYC = cyc_up(T_BLANK_500US_NS)
)
(
    input wire logic             REF_CLK,
    input wire logic             RESETN,
    input wire logic             WB_CYC_I,
    input wire logic             WB_STB_I,
    input wire logic             WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [DAT_W-1:0] WB_DAT_I,
    input wire logic [3:0]       WB_SEL_I,
    input wire logic [DAT_W-1:0] WB_DAT_O,
    input wire logic             WB_ACK_O,
    input wire logic [NCH-1:0]   OVERCURRENT,
    input wire logic [NCH-1:0]   LINE_OE,
    input wire logic [1:0]       DRIVER_LIMIT_SELECT,
    input wire logic             DRIVER_LIMIT_OFF,
    input wire logic [NCH-1:0]   DRIVER_FAULT
);
    logic [7:0] hi_r, hi_nxt, lo_r, lo_nxt;
    wire        req = WB_CYC_I && WB_STB_I;

    // latest burst length, held a few cycles so the driver switching off does not hide it
    always_comb
    begin
        lo_nxt = OVERCURRENT[0] ? 8'h00 : lo_r + {7'h0, lo_r != 8'hff};
        hi_nxt = (lo_r >= 8'h06) ? 8'h00 : hi_r;
        if (OVERCURRENT[0])
            hi_nxt = (lo_r != 8'h00) ? 8'h01 : hi_r + {7'h0, hi_r != 8'hff};
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
        if (!RESETN)
        begin
            hi_r <= 8'h00;
            lo_r <= 8'h00;
        end
        else
        begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
    ack_time_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered");
    data_high_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    limit_write_a: assert property (WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:2] == IDX_DRV
        |=> {DRIVER_LIMIT_SELECT, DRIVER_LIMIT_OFF} == $past(WB_DAT_I[7:5]))
        else $error("limit fields not written");
    limit_hold_a: assert property (!(req && WB_WE_I) |=> $stable({DRIVER_LIMIT_SELECT, DRIVER_LIMIT_OFF}))
        else $error("limit fields moved without write");
    fault_blank_a: assert property ($rose(DRIVER_FAULT[0]) |-> hi_r >= BLANK_500US_CYC)
        else $error("fault before blanking ran out");
    fault_off_a: assert property ($rose(DRIVER_FAULT[0]) |-> ##[0:2] !LINE_OE[0])
        else $error("faulted driver still on");
    fault_clear_a: assert property ($fell(DRIVER_FAULT[0]) |-> lo_r >= 8'h02)
        else $error("fault cleared under overcurrent");

    c_fault_c: cover property ($rose(DRIVER_FAULT[0]));
    c_clear_c: cover property ($fell(DRIVER_FAULT[0]));
    c_write_c: cover property (WB_ACK_O && WB_WE_I);
endmodule // cqdf_top_sva

bind cqdf_top cqdf_top_sva #(.BLANK_500US_CYC(BLANK_500US_CYC)) u_sva (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .OVERCURRENT(OVERCURRENT), .LINE_OE(LINE_OE),
    .DRIVER_LIMIT_SELECT(DRIVER_LIMIT_SELECT), .DRIVER_LIMIT_OFF(DRIVER_LIMIT_OFF),
    .DRIVER_FAULT(DRIVER_FAULT));

// >>> tb/cqdf_top_tb_top.sv
`timescale 1ns/1ps
module cqdf_top_tb_top;
    import cqdf_pkg::*;

    logic           clk, rst_n, cyc, stb, we, ack, loff;
    logic [7:0]     adr, q;
    logic [31:0]    dat_w, dat_r;
    logic [3:0]     sel;
    logic [1:0]     pin_en, pin_dat, aux, line_i, oc, line_o, line_oe;
    logic [1:0]     thr, src, snk, flt, sens, short, lsel;
    int             errors, n_compared, n;

    // only the codes the fault test uses are shortened, the others keep full length
    cqdf_top #(.BLANK_500US_CYC(20), .RETRY_50MS_CYC(50)) u_dut (
        .REF_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_DAT_I(dat_w), .WB_SEL_I(sel), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .DRIVE_ENABLE_PIN(pin_en), .DRIVE_DATA_PIN(pin_dat), .AUX_INPUT(aux), .LINE_I(line_i),
        .OVERCURRENT(oc), .LINE_O(line_o), .LINE_OE(line_oe), .THRESHOLD_TYPE_SEL(thr),
        .INPUT_SOURCE_ON(src), .INPUT_SINK_ON(snk), .DRIVER_LIMIT_SELECT(lsel),
        .DRIVER_LIMIT_OFF(loff), .DRIVER_FAULT(flt));

    cqdf_line_model u_line (.drv_o(line_o), .drv_oe(line_oe), .sensor_lvl(sens),
        .shorted(short), .line_lvl(line_i), .overcurrent(oc));

    // ********
    // helpers
    // ********
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        dat_w <= {24'h0, d};
        do
            @(posedge clk);
        while (ack !== 1'b1 && ++k < 20);
        q = dat_r[7:0];
        if (k >= 20)
            errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), e, q);
    endtask

    task wt(input int c);
        repeat (c) @(posedge clk);
    endtask

    // ********
    // scenarios
    // ********
    task t_reset;
        rd(8'h68, 8'h00);
        rd(8'h6c, 8'h00);
        rd(8'h70, 8'h00);
        rd(8'h00, 8'h00);
        rd(8'h74, 8'h00);
        rd(8'h80, 8'h00);
        $display("test reset done");
    endtask

    task t_cfg;
        wb(1'b1, 8'h68, 8'hff);
        rd(8'h68, 8'h3f);
        wb(1'b1, 8'h6c, 8'h05);
        wt(1);
        chk("thr", 8'h03, {6'h0, thr});
        chk("src", 8'h01, {6'h0, src});
        chk("snk", 8'h03, {6'h0, snk});
        chk("oe", 8'h00, {6'h0, line_oe});
        // byte lane zero off: the write must not land
        wb(1'b1, 8'h6c, 8'hff, 4'h0);
        rd(8'h6c, 8'h05);
        wb(1'b1, 8'h68, 8'h00);
        wb(1'b1, 8'h6c, 8'h00);
        $display("test cfg done");
    endtask

    task t_level;
        sens <= 2'b10;
        aux <= 2'b01;
        wt(10);
        rd(8'h68, 8'h80);
        rd(8'h6c, 8'h40);
        wb(1'b1, 8'h68, 8'h08);
        aux <= 2'b00;
        wt(10);
        aux <= 2'b01;
        wt(5);
        rd(8'h68, 8'h88);
        aux <= 2'b00;
        wt(40);
        rd(8'h68, 8'h08);
        wb(1'b1, 8'h68, 8'h00);
        $display("test level done");
    endtask

    task t_limit;
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, 8'h70, {i[1:0], i[0], 5'h00});
            wt(1);
            chk("lsel", i[7:0], {6'h0, lsel});
            chk("loff", {7'h0, i[0]}, {7'h0, loff});
        end
        // a reset in mid-run must clear what was written
        wb(1'b1, 8'h70, 8'hff);
        rst_n <= 1'b0;
        wt(2);
        rst_n <= 1'b1;
        rd(8'h70, 8'h00);
        $display("test limit done");
    endtask

    task t_pin;
        pin_en <= 2'b01;
        pin_dat <= 2'b01;
        wt(6);
        chk("oe", 8'h01, {6'h0, line_oe});
        wb(1'b1, 8'h68, 8'h20);
        wt(6);
        chk("out", 8'h01, {6'h0, line_o & line_oe});
        wb(1'b1, 8'h74, 8'h40);
        pin_en <= 2'b00;
        wt(6);
        chk("oe", 8'h01, {6'h0, line_oe});
        chk("out", 8'h00, {6'h0, line_o & line_oe});
        wb(1'b1, 8'h74, 8'h00);
        wb(1'b1, 8'h68, 8'h00);
        pin_dat <= 2'b00;
        $display("test pin done");
    endtask

    task t_fault;
        wb(1'b1, 8'h70, 8'h08);
        pin_en <= 2'b01;
        wt(6);
        short <= 2'b01;
        wt(10);
        short <= 2'b00;
        wt(10);
        chk("flt", 8'h00, {6'h0, flt});
        short <= 2'b01;
        wt(40);
        chk("flt", 8'h01, {6'h0, flt});
        wt(200);
        chk("oe", 8'h00, {6'h0, line_oe});
        rd(8'h80, 8'h01);
        wb(1'b1, 8'h70, 8'h09);
        for (n = 0; n < 100 && line_oe[0] !== 1'b1; n++) @(posedge clk);
        chk("retry on", 8'h01, {7'h0, line_oe[0]});
        wt(40);
        chk("flt", 8'h01, {6'h0, flt});
        chk("oe", 8'h00, {6'h0, line_oe});
        short <= 2'b00;
        for (n = 0; n < 200 && flt[0] !== 1'b0; n++) @(posedge clk);
        chk("flt", 8'h00, {6'h0, flt});
        wt(4);
        chk("oe", 8'h01, {6'h0, line_oe});
        wb(1'b1, 8'h70, 8'h00);
        pin_en <= 2'b00;
        $display("test fault done");
    endtask

    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #2000000;
        errors++;
        print_verdict;
    end

    initial
    begin
        {rst_n, cyc, stb, we, adr, dat_w, sel} = '0;
        {pin_en, pin_dat, aux, sens, short} = '0;
        errors = 0;
        n_compared = 0;
        wt(4);
        rst_n <= 1'b1;
        t_reset;
        t_cfg;
        t_level;
        t_limit;
        t_pin;
        t_fault;
        print_verdict;
    end
endmodule // cqdf_top_tb_top
